// >>> include/hsc_pkg.sv
package hsc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CONTROL = 8'h00; // Control: hold bit, event requests
  localparam logic [7:0] ADDR_STATUS  = 8'h04; // Live state, read only
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08; // Sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h0c; // Interrupt mask
  // Control field positions
  localparam int CTL_HOLD      = 0; // Configuration hold bit
  localparam int CTL_EXTRACT   = 1; // Software asks for extraction signalling
  localparam int CTL_PME_REQ   = 2; // Software power-management request
  localparam int CTL_STAGE_SW  = 3; // Software connection stage active
  localparam int CTL_ENUM_CLR  = 4; // Write one: release the event line
  // Status field positions
  localparam int ST_LATCH_OPEN = 0;
  localparam int ST_POWER_OK   = 1;
  localparam int ST_EEPROM_EN  = 2;
  localparam int ST_ARB_EN     = 3;
  localparam int ST_HOLD       = 4;
  localparam int ST_ENUM       = 5;
  localparam int ST_LAMP       = 6;
  // Event bit positions
  localparam int EV_INSERT     = 0;
  localparam int EV_EXTRACT    = 1;
  localparam int EV_POWER_OK   = 2;
  localparam int EV_NUM        = 3;
  // Reset values
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [EV_NUM-1:0] MASK_RST = 3'h0;
  // Serial clock divider: full period is two to the tenth core cycles
  localparam int SCL_DIV_LOG2  = 10;
  localparam int SCL_HALF      = (1 << SCL_DIV_LOG2) / 2;
endpackage : hsc_pkg

// >>> include/hsc_pins_if.sv
`timescale 1ns/100ps
// Synchronised pin levels passed from the input stage to the top
interface hsc_pins_if;
  logic latch_n;  // Ejector latch, synchronised
  logic power_n;  // Power-good, synchronised
  modport producer (output latch_n, output power_n);
  modport consumer (input latch_n, input power_n);
endinterface : hsc_pins_if

// >>> src/hsc_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for the asynchronous board pins
module hsc_sync
(
  input  wire logic     core_clk,
  input  wire logic     reset,
  input  wire logic     ejector_latch_n,
  input  wire logic     backend_power_good_n,
  hsc_pins_if.producer  pins
);
  logic [1:0] stage1; // First stage, read only by the second
  logic [1:0] stage2; // Second stage, safe to use

  // Pins park at their inactive (high) level during reset
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= 2'h3;
      stage2 <= 2'h3;
    end
    else
    begin
      stage1 <= {backend_power_good_n, ejector_latch_n};
      stage2 <= stage1;
    end
  end

  assign pins.latch_n = stage2[0];
  assign pins.power_n = stage2[1];
endmodule : hsc_sync

// >>> src/hsc_top.sv
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module hsc_top
#(
  parameter int SCL_HALF_CYCLES = hsc_pkg::SCL_HALF // Half period of serial clock
)
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        ejector_latch_n,
  input  wire logic        backend_power_good_n,
  input  wire logic        eeprom_load_strap,
  input  wire logic        arbiter_enable_strap,
  input  wire logic        config_hold_option,
  input  wire logic        pme_event,
  input  wire logic        eeprom_done,
  output logic             enum_out,
  output logic             enum_oe,
  output logic             pme_out,
  output logic             pme_oe,
  output logic             swap_indicator_lamp_n,
  output logic             lamp_oe,
  output logic             eeprom_scl,
  output logic             eeprom_load_enable,
  output logic             arbiter_enable,
  output logic             config_retry,
  output logic             backend_power_stable,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  output logic             irq
);
  hsc_pins_if pins ();

  // Synchronised pin levels
  // latch and power-good synchronised
  hsc_sync u_sync
  (
    .core_clk             (core_clk),
    .reset                (reset),
    .ejector_latch_n      (ejector_latch_n),
    .backend_power_good_n (backend_power_good_n),
    .pins                 (pins)
  );

  // Write decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic              strap_taken;       // Straps captured since reset
  logic              eeprom_en;         // Captured load strap
  logic              arb_en;            // Captured arbiter strap
  logic              hold;              // Configuration hold
  logic              extract_req;       // Software extraction request
  logic              pme_req;           // Software PME request
  logic              stage_sw;          // Software connection stage
  logic              enum_pending;      // Event line asserted
  logic              hw_stage;          // Hardware connection stage
  logic              latch_prev;        // Previous latch state
  logic [hsc_pkg::EV_NUM-1:0] ev_status; // Sticky events
  logic [hsc_pkg::EV_NUM-1:0] ev_mask;   // Interrupt enables
  logic              power_prev;        // Previous power-stable state
  logic [9:0]        div_cnt;           // Serial clock divider
  logic              scl_q;             // Serial clock level
  logic [31:0]       rdata_q;           // Read data register

  logic              next_strap_taken;
  logic              next_eeprom_en;
  logic              next_arb_en;
  logic              next_hold;
  logic              next_extract_req;
  logic              next_pme_req;
  logic              next_stage_sw;
  logic              next_enum_pending;
  logic              next_hw_stage;
  logic              next_latch_prev;
  logic [hsc_pkg::EV_NUM-1:0] next_ev_status;
  logic [hsc_pkg::EV_NUM-1:0] next_ev_mask;
  logic              next_power_prev;
  logic [9:0]        next_div_cnt;
  logic              next_scl_q;
  logic [31:0]       next_rdata_q;

  logic              latch_open;        // Latch open, decoded
  logic              power_ok;          // Back-end power stable
  logic              insert_ev;         // Insertion completed
  logic              extract_ev;        // Latch just opened
  logic [hsc_pkg::EV_NUM-1:0] ev_set;   // Event sets this cycle
  logic              ctl_wr;            // Control write
  logic              st_clr_wr;         // Status clear write

  // Decoded pin meanings
  always_comb
  begin
    latch_open = ~pins.latch_n;
    // power-good OR reset; in reset power is not stable
    power_ok   = ~(pins.power_n | reset);
    insert_ev  = power_ok & ~power_prev & ~latch_open;
    extract_ev = latch_open & ~latch_prev;
    ev_set     = '0;
    ev_set[hsc_pkg::EV_INSERT]  = insert_ev;
    ev_set[hsc_pkg::EV_EXTRACT] = extract_ev;
    ev_set[hsc_pkg::EV_POWER_OK] = power_ok & ~power_prev;
    ctl_wr     = reg_write & hit(reg_addr, hsc_pkg::ADDR_CONTROL);
    st_clr_wr  = reg_write & hit(reg_addr, hsc_pkg::ADDR_IRQ_ST);
  end

  // Next state for straps, control, events and divider
  always_comb
  begin
    next_strap_taken  = strap_taken;
    next_eeprom_en    = eeprom_en;
    next_arb_en       = arb_en;
    next_hold         = hold;
    next_extract_req  = extract_req;
    next_pme_req      = pme_req;
    next_stage_sw     = stage_sw;
    next_enum_pending = enum_pending;
    next_hw_stage     = hw_stage;
    next_latch_prev   = latch_open;
    next_power_prev   = power_ok;
    next_ev_mask      = ev_mask;
    next_div_cnt      = div_cnt;
    next_scl_q        = scl_q;
    next_rdata_q      = 32'h0000_0000;
    // capture load strap at first edge after reset
    // capture arbiter strap and hold option on the same first edge after reset
    if (!strap_taken)
    begin
      next_strap_taken = 1'b1;
      next_eeprom_en   = eeprom_load_strap;
      next_arb_en      = arbiter_enable_strap;
      next_hold        = config_hold_option;
    end
    // Software register writes
    if (ctl_wr)
    begin
      // software clears the hold bit
      // A write on the capture edge must not lose the strap value
      next_hold        = reg_wdata[hsc_pkg::CTL_HOLD] & next_hold;
      next_extract_req = reg_wdata[hsc_pkg::CTL_EXTRACT];
      next_pme_req     = reg_wdata[hsc_pkg::CTL_PME_REQ];
      next_stage_sw    = reg_wdata[hsc_pkg::CTL_STAGE_SW];
      if (reg_wdata[hsc_pkg::CTL_ENUM_CLR])
      begin
        next_enum_pending = 1'b0;
      end
    end
    if (reg_write && hit(reg_addr, hsc_pkg::ADDR_IRQ_MSK))
    begin
      next_ev_mask = reg_wdata[hsc_pkg::EV_NUM-1:0];
    end
    // Hardware stage runs from power good until hold released
    if (ev_set[hsc_pkg::EV_POWER_OK])
    begin
      next_hw_stage = 1'b1;
    end
    else if (!power_ok)
    begin
      next_hw_stage = 1'b0;
    end
    else if (hw_stage && !next_hold && !hold)
    begin
      next_hw_stage = 1'b0;
    end
    // insert, extract or extract request raises event unless hold is set; set wins over clear
    if ((insert_ev || extract_ev || (ctl_wr && reg_wdata[hsc_pkg::CTL_EXTRACT]))
        && !hold)
    begin
      next_enum_pending = 1'b1;
    end
    // Sticky events: set wins over write-one-to-clear
    next_ev_status = ev_status;
    if (st_clr_wr)
    begin
      next_ev_status = ev_status & ~reg_wdata[hsc_pkg::EV_NUM-1:0];
    end
    next_ev_status = next_ev_status | ev_set;
    // toggle every half period, full period 1024 cycles
    if (div_cnt == 10'(SCL_HALF_CYCLES - 1))
    begin
      next_div_cnt = 10'h000;
      next_scl_q   = ~scl_q;
    end
    else
    begin
      next_div_cnt = div_cnt + 10'h001;
    end
    // Read data, valid the cycle after the strobe
    if (reg_read)
    begin
      case (reg_addr)
        hsc_pkg::ADDR_CONTROL:
        begin
          next_rdata_q[hsc_pkg::CTL_HOLD]     = hold;
          next_rdata_q[hsc_pkg::CTL_EXTRACT]  = extract_req;
          next_rdata_q[hsc_pkg::CTL_PME_REQ]  = pme_req;
          next_rdata_q[hsc_pkg::CTL_STAGE_SW] = stage_sw;
        end
        hsc_pkg::ADDR_STATUS:
        begin
          next_rdata_q[hsc_pkg::ST_LATCH_OPEN] = latch_open;
          next_rdata_q[hsc_pkg::ST_POWER_OK]   = power_ok;
          next_rdata_q[hsc_pkg::ST_EEPROM_EN]  = eeprom_en;
          next_rdata_q[hsc_pkg::ST_ARB_EN]     = arb_en;
          next_rdata_q[hsc_pkg::ST_HOLD]       = hold;
          next_rdata_q[hsc_pkg::ST_ENUM]       = enum_pending;
          next_rdata_q[hsc_pkg::ST_LAMP]       = hw_stage | stage_sw;
        end
        hsc_pkg::ADDR_IRQ_ST:
        begin
          next_rdata_q[hsc_pkg::EV_NUM-1:0] = ev_status;
        end
        hsc_pkg::ADDR_IRQ_MSK:
        begin
          next_rdata_q[hsc_pkg::EV_NUM-1:0] = ev_mask;
        end
        default:
        begin
          // Unmapped addresses read zero
          next_rdata_q = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register all state
  // asynchronous reset to known state
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      strap_taken  <= 1'b0;
      eeprom_en    <= 1'b0;
      arb_en       <= 1'b0;
      hold         <= 1'b0;
      extract_req  <= 1'b0;
      pme_req      <= 1'b0;
      stage_sw     <= 1'b0;
      enum_pending <= 1'b0;
      hw_stage     <= 1'b0;
      latch_prev   <= 1'b0;
      ev_status    <= '0;
      ev_mask      <= hsc_pkg::MASK_RST;
      power_prev   <= 1'b0;
      div_cnt      <= 10'h000;
      scl_q        <= 1'b0;
      rdata_q      <= hsc_pkg::CONTROL_RST;
    end
    else
    begin
      strap_taken  <= next_strap_taken;
      eeprom_en    <= next_eeprom_en;
      arb_en       <= next_arb_en;
      hold         <= next_hold;
      extract_req  <= next_extract_req;
      pme_req      <= next_pme_req;
      stage_sw     <= next_stage_sw;
      enum_pending <= next_enum_pending;
      hw_stage     <= next_hw_stage;
      latch_prev   <= next_latch_prev;
      ev_status    <= next_ev_status;
      ev_mask      <= next_ev_mask;
      power_prev   <= next_power_prev;
      div_cnt      <= next_div_cnt;
      scl_q        <= next_scl_q;
      rdata_q      <= next_rdata_q;
    end
  end

  // Output pins
  always_comb
  begin
    // open drain, drives low while event pending
    enum_out = 1'b0;
    enum_oe  = enum_pending;
    pme_out  = 1'b0;
    pme_oe   = pme_req | pme_event;
    // lamp low in hardware or software stage
    swap_indicator_lamp_n = 1'b0;
    lamp_oe  = hw_stage | stage_sw;
    eeprom_scl = scl_q;
    // download only when strap captured high
    eeprom_load_enable = eeprom_en & strap_taken & ~eeprom_done;
    arbiter_enable = arb_en;
    config_retry = hold | ~strap_taken;
    backend_power_stable = power_ok;
    reg_rdata = rdata_q;
    irq = |(ev_status & ev_mask);
  end
endmodule : hsc_top

// >>> tb/hsc_board.sv
`timescale 1ns/100ps
// Board side: lever, back-end supply and pulled-up lines
module hsc_board
#(
  parameter int RAMP = 4 // Supply ramp in cycles
)
(
  input  wire logic core_clk,
  input  wire logic seated,
  input  wire logic lever_open,
  input  wire logic enum_out,
  input  wire logic enum_oe,
  input  wire logic pme_out,
  input  wire logic pme_oe,
  input  wire logic lamp_drv,
  input  wire logic lamp_oe,
  output logic      ejector_latch_n,
  output logic      backend_power_good_n,
  output logic      enum_line_n,
  output logic      pme_line_n,
  output logic      lamp_line_n
);
  int ramp_cnt = 0; // Cycles since seating
  // Supply ramps only while the board is seated
  always @(posedge core_clk)
  begin
    ramp_cnt <= seated ? ramp_cnt + 1 : 0;
  end
  assign backend_power_good_n = !(ramp_cnt >= RAMP);
  // Lever open pulls the latch pin low
  assign ejector_latch_n = !lever_open;
  // Released lines float up to the pull-up level
  assign enum_line_n = enum_oe ? enum_out : 1'b1;
  assign pme_line_n  = pme_oe ? pme_out : 1'b1;
  assign lamp_line_n = lamp_oe ? lamp_drv : 1'b1;
endmodule : hsc_board

// >>> tb/hsc_top_chk.sv
`timescale 1ns/100ps
// Pin-level checker for the hot-swap block
module hsc_top_chk
#(
  parameter int SCL_HALF_CYCLES = hsc_pkg::SCL_HALF // Half period of serial clock
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic backend_power_good_n,
  input wire logic pme_event,
  input wire logic eeprom_done,
  input wire logic enum_out,
  input wire logic enum_oe,
  input wire logic pme_out,
  input wire logic pme_oe,
  input wire logic swap_indicator_lamp_n,
  input wire logic lamp_oe,
  input wire logic eeprom_scl,
  input wire logic eeprom_load_enable,
  input wire logic arbiter_enable,
  input wire logic config_retry,
  input wire logic backend_power_stable
);
  default clocking @(posedge core_clk); endclocking
  logic prev_scl; // Serial clock one sample back
  int   gap;      // Cycles since last toggle
  logic seen;     // A toggle has been seen
  // Measures serial clock half periods
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      prev_scl <= 1'b0;
      gap      <= 0;
      seen     <= 1'b0;
    end
    else
    begin
      prev_scl <= eeprom_scl;
      gap      <= (eeprom_scl != prev_scl) ? 0 : gap + 1;
      seen     <= seen | (eeprom_scl != prev_scl);
    end
  end
  a_enum_drain: assert property (disable iff (reset) enum_oe |-> !enum_out)
    else $error("event line driven high");
  a_enum_hold: assert property (disable iff (reset) $rose(enum_oe) |-> !$past(config_retry))
    else $error("event line raised during hold");
  a_power_or: assert property (disable iff (reset)
    (!reset && !backend_power_good_n) [*3] |-> backend_power_stable)
    else $error("power not stable");
  a_lamp_drain: assert property (disable iff (reset) lamp_oe |-> !swap_indicator_lamp_n)
    else $error("lamp driven high");
  a_reset_state: assert property (reset |-> !backend_power_stable && !lamp_oe && !enum_oe
    && config_retry)
    else $error("reset state wrong");
  a_strap_keep: assert property (disable iff (reset)
    !$past(reset) && !$past(reset, 2) && !$past(reset, 3) |-> $stable(arbiter_enable))
    else $error("arbiter strap changed");
  a_scl_gap: assert property (disable iff (reset)
    (eeprom_scl != prev_scl) && seen |-> gap == SCL_HALF_CYCLES - 1)
    else $error("serial clock half period wrong");
  a_scl_bound: assert property (disable iff (reset) seen |-> gap < SCL_HALF_CYCLES)
    else $error("serial clock stalled");
  a_pme_event: assert property (disable iff (reset) pme_event |-> pme_oe && !pme_out)
    else $error("power event not signalled");
  a_load_done: assert property (disable iff (reset) eeprom_done |-> !eeprom_load_enable)
    else $error("load enable after done");
endmodule : hsc_top_chk
bind hsc_top hsc_top_chk #(.SCL_HALF_CYCLES(SCL_HALF_CYCLES)) hsc_top_chk_i (.core_clk,
  .reset, .backend_power_good_n, .pme_event, .eeprom_done, .enum_out, .enum_oe, .pme_out,
  .pme_oe, .swap_indicator_lamp_n, .lamp_oe, .eeprom_scl, .eeprom_load_enable,
  .arbiter_enable, .config_retry, .backend_power_stable);

// >>> tb/hsc_top_test.sv
`timescale 1ns/100ps
// Self-checking bench for the hot-swap block
module hsc_top_test;
  logic        core_clk, reset, seated, lever_open, pme_event, eeprom_done;
  logic        ee_strap, arb_strap, hold_strap, latch_n, power_n;
  logic        enum_out, enum_oe, pme_out, pme_oe, lamp_drv, lamp_oe, scl;
  logic        load_en, arb_en, config_retry, power_stable, irq;
  logic        enum_n, pme_n, lamp_n, reg_write, reg_read;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  bit          hold_m, ee_m, arb_m, open_m, pok_m, enum_m, lamp_m; // Reference model
  int          failures, check_count, cycles;
  hsc_top #(.SCL_HALF_CYCLES(4)) hsc_top_i (.core_clk, .reset, .ejector_latch_n(latch_n),
    .backend_power_good_n(power_n), .eeprom_load_strap(ee_strap),
    .arbiter_enable_strap(arb_strap), .config_hold_option(hold_strap), .pme_event,
    .eeprom_done, .enum_out, .enum_oe, .pme_out, .pme_oe, .swap_indicator_lamp_n(lamp_drv),
    .lamp_oe, .eeprom_scl(scl), .eeprom_load_enable(load_en), .arbiter_enable(arb_en),
    .config_retry, .backend_power_stable(power_stable), .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .irq);
  hsc_board hsc_board_i (.core_clk, .seated, .lever_open, .enum_out, .enum_oe, .pme_out,
    .pme_oe, .lamp_drv, .lamp_oe, .ejector_latch_n(latch_n), .backend_power_good_n(power_n),
    .enum_line_n(enum_n), .pme_line_n(pme_n), .lamp_line_n(lamp_n));
  // Free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Cuts a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 4000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask : chk_pin
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk_reg(reg_rdata, exp);
  endtask : reg_rd
  // Expected status word from the model
  function automatic logic [31:0] exp_st();
    logic [31:0] s;
    s = 32'h0;
    s[hsc_pkg::ST_LATCH_OPEN] = open_m;
    s[hsc_pkg::ST_POWER_OK] = pok_m;
    s[hsc_pkg::ST_EEPROM_EN] = ee_m;
    s[hsc_pkg::ST_ARB_EN] = arb_m;
    s[hsc_pkg::ST_HOLD] = hold_m;
    s[hsc_pkg::ST_ENUM] = enum_m;
    s[hsc_pkg::ST_LAMP] = lamp_m;
    return s;
  endfunction : exp_st
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Main sequence: one pass with the hold option, one without
  initial
  begin
    {reset, seated, lever_open, pme_event, eeprom_done, reg_write, reg_read} = 7'h40;
    {ee_strap, arb_strap, hold_strap, reg_addr, reg_wdata} = '0;
    void'($urandom(32'h7e83d5ca));
    for (int h = 1; h >= 0; h--)
    begin
      seated <= 1'b0;
      lever_open <= 1'b0;
      hold_strap <= h[0];
      ee_strap <= 1'($urandom);
      arb_strap <= 1'($urandom);
      reset <= 1'b1;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      {hold_m, ee_m, arb_m, open_m, pok_m, enum_m, lamp_m} = {h[0], ee_strap, arb_strap, 4'h0};
      reg_rd(hsc_pkg::ADDR_STATUS, exp_st());
      reg_rd(hsc_pkg::ADDR_IRQ_MSK, 32'(hsc_pkg::MASK_RST));
      chk_pin(config_retry, h[0]);
      chk_pin(arb_en, arb_m);
      {ee_strap, arb_strap, hold_strap} <= ~{ee_strap, arb_strap, hold_strap};
      seated <= 1'b1;
      repeat (12) @(posedge core_clk);
      {pok_m, enum_m, lamp_m} = {1'b1, !h[0], h[0]};
      reg_rd(hsc_pkg::ADDR_STATUS, exp_st());
      chk_pin(power_stable, 1'b1);
      chk_pin(enum_n, !enum_m);
      chk_pin(lamp_n, !lamp_m);
      if (!h[0]) reg_rd(hsc_pkg::ADDR_IRQ_ST, 32'h5);
      reg_wr(hsc_pkg::ADDR_CONTROL, 32'h0);
      reg_wr(hsc_pkg::ADDR_CONTROL, 32'h1);
      {hold_m, lamp_m} = 2'b00;
      reg_rd(hsc_pkg::ADDR_STATUS, exp_st());
      chk_pin(config_retry, 1'b0);
      reg_wr(hsc_pkg::ADDR_CONTROL, 32'h18);
      {enum_m, lamp_m} = 2'b01;
      reg_rd(hsc_pkg::ADDR_STATUS, exp_st());
      chk_pin(lamp_n, 1'b0);
      reg_wr(hsc_pkg::ADDR_CONTROL, 32'h2);
      {enum_m, lamp_m} = 2'b10;
      reg_rd(hsc_pkg::ADDR_STATUS, exp_st());
      reg_rd(hsc_pkg::ADDR_CONTROL, 32'h2);
      reg_wr(hsc_pkg::ADDR_CONTROL, 32'h10);
      enum_m = 1'b0;
      reg_rd(hsc_pkg::ADDR_STATUS, exp_st());
      reg_wr(hsc_pkg::ADDR_IRQ_ST, 32'h7);
      reg_wr(hsc_pkg::ADDR_IRQ_MSK, 32'h2);
      lever_open <= 1'b1;
      {open_m, enum_m, lamp_m} = 3'b110;
      repeat (6) @(posedge core_clk);
      reg_rd(hsc_pkg::ADDR_STATUS, exp_st());
      reg_rd(hsc_pkg::ADDR_IRQ_ST, 32'h2);
      chk_pin(irq, 1'b1);
      chk_pin(enum_n, 1'b0);
      reg_wr(hsc_pkg::ADDR_IRQ_MSK, 32'h5);
      reg_rd(hsc_pkg::ADDR_IRQ_MSK, 32'h5);
      chk_pin(irq, 1'b0);
      reg_wr(hsc_pkg::ADDR_IRQ_ST, 32'h2);
      reg_rd(hsc_pkg::ADDR_IRQ_ST, 32'h0);
      reg_rd(8'h10, 32'h0);
      pme_event <= 1'b1;
      @(posedge core_clk);
      #1 chk_pin(pme_n, 1'b0);
      pme_event <= 1'b0;
      reg_wr(hsc_pkg::ADDR_CONTROL, 32'h4);
      #1 chk_pin(pme_n, 1'b0);
      reg_wr(hsc_pkg::ADDR_CONTROL, 32'h0);
      #1 chk_pin(pme_n, 1'b1);
      chk_pin(load_en, ee_m);
      eeprom_done <= 1'b1;
      @(posedge core_clk);
      #1 chk_pin(load_en, 1'b0);
      eeprom_done <= 1'b0;
      $display("Test with hold option %0d finished", h);
    end
    finish_test();
  end
endmodule : hsc_top_test
